/* File: rtl/pef_pkg.sv */
// Package with offsets, field positions, reset values and scan states of the port override block.
package pef_pkg;
    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_A_DIR = 8'h00;
    localparam logic [7:0] ADDR_A_PIN = 8'h04;
    localparam logic [7:0] ADDR_A_OUT = 8'h08;
    localparam logic [7:0] ADDR_B_OUT = 8'h0C;
    localparam logic [7:0] ADDR_B_DIR = 8'h10;
    localparam logic [7:0] ADDR_B_PIN = 8'h14;
    localparam logic [7:0] ADDR_E_OUT = 8'h18;
    localparam logic [7:0] ADDR_E_DIR = 8'h1C;
    localparam logic [7:0] ADDR_E_PIN = 8'h20;
    localparam logic [7:0] ADDR_F_OUT = 8'h24;
    localparam logic [7:0] ADDR_F_DIR = 8'h28;
    localparam logic [7:0] ADDR_F_PIN = 8'h2C;
    localparam logic [7:0] ADDR_CTRL = 8'h30;
    localparam logic [7:0] ADDR_STAT = 8'h34;

    // ------------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_PORT = 8'h00;
    localparam int CTRL_PUD_BIT = 0;
    localparam int STAT_HWB_BIT = 0;
    localparam int STAT_BOOT_BIT = 1;
    localparam int STAT_SCAN_BIT = 2;
    localparam int E_IDENT_BIT = 3;
    localparam int E_ALE_BIT = 2;
    localparam int F_TDI_BIT = 7;
    localparam int F_TMS_BIT = 5;
    localparam int F_TCK_BIT = 4;

    // ------------------------------------------------------------------
    // Scan controller constants
    // ------------------------------------------------------------------
    localparam int IR_WIDTH = 4;
    localparam logic [3:0] IR_BYPASS = 4'hF;
    localparam logic [3:0] IR_SAMPLE = 4'h2;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam int CHAIN_WIDTH = 8;
    // Clock edges after reset release before synchronised pins are valid.
    localparam logic [1:0] BOOT_SETTLE = 2'h2;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
        TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } pef_tap_t;
endpackage

/* File: rtl/pef_port_override.sv */
// Pin override logic for ports E and F, port A/B registers, scan controller and APB slave.
//
// How it works
// - Port E upper pins: bus power out, irq inputs
// - Ident pin forced input with pull-up
// - Memory strobes drive port E bits 2..0
// - Scan port overrides port F bits 7..4
// - Scan data output driven only while shifting
// - Scan pull-ups stay on through reset
// - Scan pins withheld from general I/O
// - Scan runs on test clock, mode-select sequenced
// - Shift test data into selected register
// - Port F low pins get no override
// - Port A/B direction registers reset to zero
// - Port B output register resets to zero
// - Pin level register has no reset value
// - Boot pin low at reset selects bootloader
// - Bus power output is active high
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/10ps
module pef_port_override
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] portAIn,
    output logic [7:0] portAOut,
    output logic [7:0] portAOe,
    output logic [7:0] portAPullup,
    input wire logic [7:0] portBIn,
    output logic [7:0] portBOut,
    output logic [7:0] portBOe,
    output logic [7:0] portBPullup,
    input wire logic [7:0] portEIn,
    output logic [7:0] portEOut,
    output logic [7:0] portEOe,
    output logic [7:0] portEPullup,
    output logic [7:0] portEDinEn,
    input wire logic [7:0] portFIn,
    output logic [7:0] portFOut,
    output logic [7:0] portFOe,
    output logic [7:0] portFPullup,
    output logic [7:0] portFDinEn,
    input wire logic busPowerCtrlEn,
    input wire logic busPowerCtrlOut,
    input wire logic identPinEn,
    input wire logic extMemIfEn,
    input wire logic extMemAle,
    input wire logic extMemRd,
    input wire logic extMemWr,
    input wire logic [3:0] extIrqEn,
    input wire logic sleepInputOff,
    input wire logic scanPortEn,
    input wire logic hwBootFuseEn,
    output logic usbIdentIn,
    output logic hwBootSelect,
    output logic bootLoaderStart,
    output logic [3:0] extIrqIn
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Per-bit select of override value over the register-derived setting.
    function automatic logic [7:0] ovr8(input logic [7:0] en, input logic [7:0] val,
                                        input logic [7:0] base);
        ovr8 = (en & val) | (~en & base);
    endfunction

    // Pull-up from the register pair: enabled for inputs with the data bit set while pud is clear.
    function automatic logic [7:0] pull8(input logic [7:0] dat, input logic [7:0] dir,
                                         input logic pud);
        pull8 = dat & ~dir & ~{8{pud}};
    endfunction

    logic [7:0] portADirection_reg;
    logic [7:0] portAOutputValue_reg;
    logic [7:0] portBOutputValue_reg;
    logic [7:0] portBDirection_reg;
    logic [7:0] portEOutput_reg;
    logic [7:0] portEDirection_reg;
    logic [7:0] portFOutput_reg;
    logic [7:0] portFDirection_reg;
    logic pullupDisable_reg;
    logic [31:0] pinSync1_reg;
    logic [31:0] pinSync2_reg;
    logic [1:0] bootCnt_reg;
    logic bootLoaderStart_reg;
    logic [31:0] prdata_reg;
    logic tckPrev_reg;
    pef_pkg::pef_tap_t tapState_reg;
    pef_pkg::pef_tap_t tapState_next;
    logic [3:0] irShift_reg;
    logic [3:0] ir_reg;
    logic bypass_reg;
    logic [7:0] chain_reg;
    logic scanDataOut_reg;
    logic tckRise;
    logic tckFall;
    logic shiftActive;
    logic [7:0] eSync;
    logic [7:0] fSync;
    logic [7:0] eDinEnable;
    logic [7:0] fDinEnable;
    logic [7:0] eOe;
    logic [7:0] ePe;
    logic [7:0] ePv;
    logic [7:0] eDe;
    logic [7:0] fOe;
    logic [7:0] fPe;
    logic [7:0] fPv;
    logic [7:0] fDe;
    logic [7:0] fDdov;
    logic [7:0] fPvov;
    logic wrEn;
    logic [7:0] statByte;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Two stages with no reset, so the sampled levels carry no reset value.
    always_ff @(posedge clk_sys)
    begin
        pinSync1_reg <= {portFIn, portEIn, portBIn, portAIn};
        pinSync2_reg <= pinSync1_reg;
    end

    assign eSync = pinSync2_reg[23:16];
    assign fSync = pinSync2_reg[31:24];

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    assign wrEn = psel & penable & pwrite;
    assign pready = 1'b1;
    assign prdata = prdata_reg;

    // Unmapped offsets answer with an error in the access phase.
    always_comb
    begin
        case (paddr)
            pef_pkg::ADDR_A_DIR, pef_pkg::ADDR_A_PIN, pef_pkg::ADDR_A_OUT,
            pef_pkg::ADDR_B_OUT, pef_pkg::ADDR_B_DIR, pef_pkg::ADDR_B_PIN,
            pef_pkg::ADDR_E_OUT, pef_pkg::ADDR_E_DIR, pef_pkg::ADDR_E_PIN,
            pef_pkg::ADDR_F_OUT, pef_pkg::ADDR_F_DIR, pef_pkg::ADDR_F_PIN,
            pef_pkg::ADDR_CTRL, pef_pkg::ADDR_STAT: pslverr = 1'b0;
            default: pslverr = psel & penable;
        endcase
    end

    // Register writes take effect at the access edge.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            portADirection_reg <= pef_pkg::RST_PORT;
            portAOutputValue_reg <= pef_pkg::RST_PORT;
            portBOutputValue_reg <= pef_pkg::RST_PORT;
            portBDirection_reg <= pef_pkg::RST_PORT;
            portEOutput_reg <= pef_pkg::RST_PORT;
            portEDirection_reg <= pef_pkg::RST_PORT;
            portFOutput_reg <= pef_pkg::RST_PORT;
            portFDirection_reg <= pef_pkg::RST_PORT;
            pullupDisable_reg <= 1'b0;
        end
        else if (wrEn)
        begin
            case (paddr)
                pef_pkg::ADDR_A_DIR: portADirection_reg <= pwdata[7:0];
                pef_pkg::ADDR_A_OUT: portAOutputValue_reg <= pwdata[7:0];
                pef_pkg::ADDR_B_OUT: portBOutputValue_reg <= pwdata[7:0];
                pef_pkg::ADDR_B_DIR: portBDirection_reg <= pwdata[7:0];
                pef_pkg::ADDR_E_OUT: portEOutput_reg <= pwdata[7:0];
                pef_pkg::ADDR_E_DIR: portEDirection_reg <= pwdata[7:0];
                pef_pkg::ADDR_F_OUT: portFOutput_reg <= pwdata[7:0];
                pef_pkg::ADDR_F_DIR: portFDirection_reg <= pwdata[7:0];
                pef_pkg::ADDR_CTRL: pullupDisable_reg <= pwdata[pef_pkg::CTRL_PUD_BIT];
                default: pullupDisable_reg <= pullupDisable_reg;
            endcase
        end
    end

    // Status byte: boot pin level, latched boot choice, scan enable.
    always_comb
    begin
        statByte = 8'h00;
        statByte[pef_pkg::STAT_HWB_BIT] = hwBootSelect;
        statByte[pef_pkg::STAT_BOOT_BIT] = bootLoaderStart_reg;
        statByte[pef_pkg::STAT_SCAN_BIT] = scanPortEn;
    end

    // Read data is captured in the setup cycle and held for the access phase.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            prdata_reg <= 32'h0000_0000;
        else if (psel && !penable)
        begin
            case (paddr)
                pef_pkg::ADDR_A_DIR: prdata_reg <= {24'h000000, portADirection_reg};
                pef_pkg::ADDR_A_PIN: prdata_reg <= {24'h000000, pinSync2_reg[7:0]};
                pef_pkg::ADDR_A_OUT: prdata_reg <= {24'h000000, portAOutputValue_reg};
                pef_pkg::ADDR_B_OUT: prdata_reg <= {24'h000000, portBOutputValue_reg};
                pef_pkg::ADDR_B_DIR: prdata_reg <= {24'h000000, portBDirection_reg};
                pef_pkg::ADDR_B_PIN: prdata_reg <= {24'h000000, pinSync2_reg[15:8]};
                pef_pkg::ADDR_E_OUT: prdata_reg <= {24'h000000, portEOutput_reg};
                pef_pkg::ADDR_E_DIR: prdata_reg <= {24'h000000, portEDirection_reg};
                pef_pkg::ADDR_E_PIN: prdata_reg <= {24'h000000, eSync & eDinEnable};
                pef_pkg::ADDR_F_OUT: prdata_reg <= {24'h000000, portFOutput_reg};
                pef_pkg::ADDR_F_DIR: prdata_reg <= {24'h000000, portFDirection_reg};
                pef_pkg::ADDR_F_PIN: prdata_reg <= {24'h000000, fSync & fDinEnable};
                pef_pkg::ADDR_CTRL: prdata_reg <= {31'h00000000, pullupDisable_reg};
                pef_pkg::ADDR_STAT: prdata_reg <= {24'h000000, statByte};
                default: prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Ports A and B: plain register-driven pins
    // ------------------------------------------------------------------
    assign portAOut = portAOutputValue_reg;
    assign portAOe = portADirection_reg;
    assign portAPullup = pull8(portAOutputValue_reg, portADirection_reg, pullupDisable_reg);
    assign portBOut = portBOutputValue_reg;
    assign portBOe = portBDirection_reg;
    assign portBPullup = pull8(portBOutputValue_reg, portBDirection_reg, pullupDisable_reg);

    // ------------------------------------------------------------------
    // Port E overrides
    // ------------------------------------------------------------------
    // Bit 7 carries bus power, bit 3 ident, bits 2..0 memory strobes.
    always_comb
    begin
        eOe = {busPowerCtrlEn, 3'b000, identPinEn, {3{extMemIfEn}}};
        ePe = {busPowerCtrlEn, 3'b000, 1'b0, {3{extMemIfEn}}};
        ePv = {busPowerCtrlOut, 3'b000, 1'b0, extMemAle, extMemRd, extMemWr};
        eDe = {extIrqEn, identPinEn, 3'b000};
    end

    assign eDinEnable = ovr8(eDe, 8'hF8, {8{~sleepInputOff}});
    assign portEDinEn = eDinEnable;
    assign portEOe = ovr8(eOe, {busPowerCtrlEn, 3'b000, 1'b0, 3'b111}, portEDirection_reg);
    assign portEOut = ovr8(ePe, ePv, portEOutput_reg);
    // No pull-up override on bits 7..4 or bit 2; ident forces on, strobes on bits 1..0 force off.
    assign portEPullup = ovr8({4'h0, identPinEn, 1'b0, {2{extMemIfEn}}}, 8'h08,
                              pull8(portEOutput_reg, portEDirection_reg,
                                    pullupDisable_reg));
    assign usbIdentIn = eSync[pef_pkg::E_IDENT_BIT] & eDinEnable[pef_pkg::E_IDENT_BIT];
    assign hwBootSelect = eSync[pef_pkg::E_ALE_BIT] & eDinEnable[pef_pkg::E_ALE_BIT];
    assign extIrqIn = eSync[7:4] & eDinEnable[7:4];

    // ------------------------------------------------------------------
    // Boot selection capture
    // ------------------------------------------------------------------
    // The pin is sampled once the synchronisers hold real levels after release.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            bootCnt_reg <= 2'h0;
            bootLoaderStart_reg <= 1'b0;
        end
        else if (bootCnt_reg < pef_pkg::BOOT_SETTLE)
            bootCnt_reg <= bootCnt_reg + 2'h1;
        else if (bootCnt_reg == pef_pkg::BOOT_SETTLE)
        begin
            bootCnt_reg <= 2'h3;
            bootLoaderStart_reg <= hwBootFuseEn & ~eSync[pef_pkg::E_ALE_BIT];
        end
    end

    assign bootLoaderStart = bootLoaderStart_reg;

    // ------------------------------------------------------------------
    // Port F overrides
    // ------------------------------------------------------------------
    // Upper four pins belong to the scan port; lower four get no override.
    always_comb
    begin
        fOe = {{4{scanPortEn}}, 4'h0};
        fPe = {1'b0, scanPortEn, 2'b00, 4'h0};
        fDdov = {1'b0, shiftActive, 2'b00, 4'h0};
        fPvov = {1'b0, scanDataOut_reg, 2'b00, 4'h0};
        fDe = {{4{scanPortEn}}, 4'h0};
    end

    assign fDinEnable = ovr8(fDe, 8'h00, {8{~sleepInputOff}});
    assign portFDinEn = fDinEnable;
    assign portFOe = ovr8(fOe, fDdov, portFDirection_reg);
    assign portFOut = ovr8(fPe, fPvov, portFOutput_reg);
    // Combinational from the enable, so the pull-ups hold through reset.
    assign portFPullup = ovr8(fOe, 8'hB0,
                              pull8(portFOutput_reg, portFDirection_reg,
                                    pullupDisable_reg));

    // ------------------------------------------------------------------
    // Scan controller
    // ------------------------------------------------------------------
    assign tckRise = pinSync2_reg[24 + pef_pkg::F_TCK_BIT] & ~tckPrev_reg;
    assign tckFall = ~pinSync2_reg[24 + pef_pkg::F_TCK_BIT] & tckPrev_reg;
    assign shiftActive = scanPortEn &
                         (tapState_reg == pef_pkg::TAP_SHIFT_IR ||
                          tapState_reg == pef_pkg::TAP_SHIFT_DR);

    // Next controller state from the mode-select level at a test clock rise.
    always_comb
    begin
        logic tms;
        tms = pinSync2_reg[24 + pef_pkg::F_TMS_BIT];
        case (tapState_reg)
            pef_pkg::TAP_RESET: tapState_next = tms ? pef_pkg::TAP_RESET : pef_pkg::TAP_IDLE;
            pef_pkg::TAP_IDLE: tapState_next = tms ? pef_pkg::TAP_SEL_DR : pef_pkg::TAP_IDLE;
            pef_pkg::TAP_SEL_DR: tapState_next = tms ? pef_pkg::TAP_SEL_IR : pef_pkg::TAP_CAP_DR;
            pef_pkg::TAP_CAP_DR, pef_pkg::TAP_SHIFT_DR:
                tapState_next = tms ? pef_pkg::TAP_EXIT1_DR : pef_pkg::TAP_SHIFT_DR;
            pef_pkg::TAP_EXIT1_DR:
                tapState_next = tms ? pef_pkg::TAP_UPD_DR : pef_pkg::TAP_PAUSE_DR;
            pef_pkg::TAP_PAUSE_DR:
                tapState_next = tms ? pef_pkg::TAP_EXIT2_DR : pef_pkg::TAP_PAUSE_DR;
            pef_pkg::TAP_EXIT2_DR:
                tapState_next = tms ? pef_pkg::TAP_UPD_DR : pef_pkg::TAP_SHIFT_DR;
            pef_pkg::TAP_SEL_IR: tapState_next = tms ? pef_pkg::TAP_RESET : pef_pkg::TAP_CAP_IR;
            pef_pkg::TAP_CAP_IR, pef_pkg::TAP_SHIFT_IR:
                tapState_next = tms ? pef_pkg::TAP_EXIT1_IR : pef_pkg::TAP_SHIFT_IR;
            pef_pkg::TAP_EXIT1_IR:
                tapState_next = tms ? pef_pkg::TAP_UPD_IR : pef_pkg::TAP_PAUSE_IR;
            pef_pkg::TAP_PAUSE_IR:
                tapState_next = tms ? pef_pkg::TAP_EXIT2_IR : pef_pkg::TAP_PAUSE_IR;
            pef_pkg::TAP_EXIT2_IR:
                tapState_next = tms ? pef_pkg::TAP_UPD_IR : pef_pkg::TAP_SHIFT_IR;
            pef_pkg::TAP_UPD_DR, pef_pkg::TAP_UPD_IR:
                tapState_next = tms ? pef_pkg::TAP_SEL_DR : pef_pkg::TAP_IDLE;
            default: tapState_next = pef_pkg::TAP_RESET;
        endcase
    end

    // Controller state steps only on test clock rises; disabled port holds reset.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            tckPrev_reg <= 1'b1;
            tapState_reg <= pef_pkg::TAP_RESET;
        end
        else
        begin
            tckPrev_reg <= pinSync2_reg[24 + pef_pkg::F_TCK_BIT];
            if (!scanPortEn)
                tapState_reg <= pef_pkg::TAP_RESET;
            else if (tckRise)
                tapState_reg <= tapState_next;
        end
    end

    // Instruction chain captures, shifts and updates, data chain captures and shifts, on test clock rises.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            irShift_reg <= pef_pkg::IR_CAPTURE;
            ir_reg <= pef_pkg::IR_BYPASS;
            bypass_reg <= 1'b0;
            chain_reg <= 8'h00;
        end
        else if (tapState_reg == pef_pkg::TAP_RESET)
            ir_reg <= pef_pkg::IR_BYPASS;
        else if (tckRise)
        begin
            case (tapState_reg)
                pef_pkg::TAP_CAP_IR: irShift_reg <= pef_pkg::IR_CAPTURE;
                pef_pkg::TAP_SHIFT_IR:
                    irShift_reg <= {pinSync2_reg[24 + pef_pkg::F_TDI_BIT],
                                    irShift_reg[pef_pkg::IR_WIDTH-1:1]};
                pef_pkg::TAP_UPD_IR: ir_reg <= irShift_reg;
                pef_pkg::TAP_CAP_DR:
                begin
                    bypass_reg <= 1'b0;
                    chain_reg <= eSync;
                end
                pef_pkg::TAP_SHIFT_DR:
                begin
                    if (ir_reg == pef_pkg::IR_SAMPLE)
                        chain_reg <= {pinSync2_reg[24 + pef_pkg::F_TDI_BIT],
                                      chain_reg[pef_pkg::CHAIN_WIDTH-1:1]};
                    else
                        bypass_reg <= pinSync2_reg[24 + pef_pkg::F_TDI_BIT];
                end
                default: bypass_reg <= bypass_reg;
            endcase
        end
    end

    // Scan data out changes on test clock falls, from the selected register.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            scanDataOut_reg <= 1'b0;
        else if (tckFall)
        begin
            if (tapState_reg == pef_pkg::TAP_SHIFT_IR)
                scanDataOut_reg <= irShift_reg[0];
            else if (ir_reg == pef_pkg::IR_SAMPLE)
                scanDataOut_reg <= chain_reg[0];
            else
                scanDataOut_reg <= bypass_reg;
        end
    end
endmodule

/* File: sim/pef_port_override_assertions.sv */
// Checker of the pin override relations at the override block ports.
`timescale 1ns/10ps
module pef_port_override_assertions
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [7:0] portAOe,
    input wire logic [7:0] portBOe,
    input wire logic [7:0] portBOut,
    input wire logic [7:0] portEOut,
    input wire logic [7:0] portEOe,
    input wire logic [7:0] portEPullup,
    input wire logic [7:0] portEDinEn,
    input wire logic [7:0] portFIn,
    input wire logic [7:0] portFOe,
    input wire logic [7:0] portFPullup,
    input wire logic [7:0] portFDinEn,
    input wire logic busPowerCtrlEn,
    input wire logic busPowerCtrlOut,
    input wire logic identPinEn,
    input wire logic extMemIfEn,
    input wire logic [3:0] extIrqEn,
    input wire logic scanPortEn
);
    // --------
    // Overrides
    // --------
    // Each property but a_dir_reset and a_tdo_on_tck ties a pin setting to the function input that owns it.
    a_bus_power_out: assert property (@(posedge clk_sys) disable iff (!nrst)
        busPowerCtrlEn |-> portEOe[7] && portEOut[7] == busPowerCtrlOut) else $error("pe7 bad");
    a_irq_din_on: assert property (@(posedge clk_sys) disable iff (!nrst)
        (portEDinEn[7:4] & extIrqEn) == extIrqEn) else $error("irq input off");
    a_ident_input: assert property (@(posedge clk_sys) disable iff (!nrst)
        identPinEn |-> !portEOe[3] && portEPullup[3] && portEDinEn[3]) else $error("pe3 bad");
    a_mem_strobes: assert property (@(posedge clk_sys) disable iff (!nrst)
        extMemIfEn |-> portEOe[2:0] == 3'h7 && portEPullup[1:0] == 2'h0) else $error("strobes");
    a_scan_pin_ctl: assert property (@(posedge clk_sys) disable iff (!nrst)
        scanPortEn |-> portFPullup[7:4] == 4'hB && portFDinEn[7:4] == 4'h0
        && {portFOe[7], portFOe[5:4]} == 3'h0) else $error("scan pins");
    a_tdo_on_tck: assert property (@(posedge clk_sys) disable iff (!nrst)
        scanPortEn && $rose(portFOe[6]) |-> portFIn[4] && $past(portFIn[4])) else $error("tdo");
    a_scan_pull_rst: assert property (@(posedge clk_sys)
        scanPortEn && !nrst |-> portFPullup[7:4] == 4'hB) else $error("scan pull-up in reset");
    a_dir_reset: assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(nrst) |-> portAOe == 8'h00 && portBOe == 8'h00 && portBOut == 8'h00)
        else $error("port registers not clear");
endmodule
bind pef_port_override pef_port_override_assertions i_pef_port_override_assertions (.*);

/* File: sim/pef_board_model.sv */
// Board and tester model that resolves pin levels from all drivers.
`timescale 1ns/10ps
module pef_board_model
(
    input wire logic clk_sys,
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOe,
    input wire logic [7:0] pinPullup,
    input wire logic [7:0] extDrive,
    input wire logic [7:0] extOe,
    output logic [7:0] pinLevel
);
    logic [7:0] floatPat = 8'h55;
    // A floating line without pull-up changes every cycle, so no stale value passes.
    always_ff @(posedge clk_sys) floatPat <= ~floatPat;
    // The device wins, then the board driver, then the pull-up.
    assign pinLevel = (pinOe & pinOut) | (~pinOe & extOe & extDrive)
        | (~pinOe & ~extOe & (pinPullup | floatPat));
endmodule

/* File: sim/pef_port_override_tb_top.sv */
// Self-checking bench for the port override block.
`timescale 1ns/10ps
module pef_port_override_tb_top;
    logic clk_sys = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, portAIn = 8'h5A, portBIn = 8'hC3, eExt = 8'hFB, fExt = 8'hFF;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic pready, pslverr, errSeen, usbIdentIn, hwBootSelect, bootLoaderStart;
    logic [7:0] portAOut, portAOe, portAPullup, portBOut, portBOe, portBPullup, portEIn;
    logic [7:0] portEOut, portEOe, portEPullup, portEDinEn, portFIn, portFOut, portFOe;
    logic [7:0] portFPullup, portFDinEn, dout;
    logic busPowerCtrlEn = 1'b0, busPowerCtrlOut = 1'b0, identPinEn = 1'b0, extMemIfEn = 1'b0;
    logic extMemAle = 1'b0, extMemRd = 1'b0, extMemWr = 1'b0, sleepInputOff = 1'b0;
    logic scanPortEn = 1'b1, hwBootFuseEn = 1'b1;
    logic [3:0] extIrqEn = 4'h0, extIrqIn;
    typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} pef_row_t;
    pef_row_t rows [5] = '{'{pef_pkg::ADDR_A_DIR, 8'hFF, 8'hFF},
        '{pef_pkg::ADDR_B_OUT, 8'hA5, 8'hA5}, '{pef_pkg::ADDR_B_DIR, 8'h3C, 8'h3C},
        '{pef_pkg::ADDR_A_PIN, 8'h00, 8'h5A}, '{pef_pkg::ADDR_F_DIR, 8'hFF, 8'hFF}};
    int nErrors = 0, compares = 0;

    // --------
    // Harness
    // --------
    // Clock, design and the two pin boards.
    always #12.5 clk_sys = ~clk_sys;
    pef_port_override i_pef_port_override (.*);
    pef_board_model i_pef_board_model (.clk_sys(clk_sys), .pinOut(portEOut), .pinOe(portEOe),
        .pinPullup(portEPullup), .extDrive(eExt), .extOe(8'hFF), .pinLevel(portEIn));
    pef_board_model i_pef_board_model_f (.clk_sys(clk_sys), .pinOut(portFOut), .pinOe(portFOe),
        .pinPullup(portFPullup), .extDrive(fExt), .extOe(8'hB0), .pinLevel(portFIn));

    // --------
    // Tasks
    // --------
    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("counts: %0d compares, %0d mismatches", compares, nErrors);
        if (nErrors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            nErrors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready is seen, then an idle edge.
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge clk_sys);
            i++;
        end
        while (pready !== 1'b1 && i < 16);
        if (i >= 16)
        begin
            nErrors++;
            give_verdict();
        end
        rdata = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    // One test clock period with mode-select and data set while the clock is low.
    task automatic tck(input logic tms, input logic tdi);
        fExt <= {tdi, 1'b1, tms, 1'b0, 4'h0};
        repeat (6) @(posedge clk_sys);
        fExt[4] <= 1'b1;
        repeat (6) @(posedge clk_sys);
    endtask
    // Walks the controller with a mode-select sequence, first bit first.
    task automatic walk(input logic [9:0] seq, input int n);
        for (int i = 0; i < n; i++)
            tck(seq[i], 1'b0);
    endtask
    // Shifts n bits first bit first, the last with mode-select high.
    task automatic scan(input logic [7:0] din, input int n, output logic [7:0] q);
        q = 8'h00;
        for (int i = 0; i < n; i++)
        begin
            tck(i == n - 1, din[i]);
            q[i] = portFOut[6];
        end
    endtask

    // --------
    // Sequence
    // --------
    // Reset, register table, overrides, then scan traffic.
    initial
    begin
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (5) @(posedge clk_sys);
        check({31'h0, bootLoaderStart}, 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            apb(rows[i].a, 1'b0, 32'h0);
            check(rdata, 32'h0);
        end
        $display("test reset done");
        foreach (rows[i])
        begin
            apb(rows[i].a, 1'b1, {24'h0, rows[i].w});
            apb(rows[i].a, 1'b0, 32'h0);
            check(rdata, {24'h0, rows[i].e});
        end
        apb(8'hFC, 1'b1, 32'h77);
        check({31'h0, errSeen}, 32'h1);
        check({portBPullup, portAOe, portBOut, portBOe}, 32'h81FFA53C);
        check({24'h0, portFOe & 8'hBF}, 32'h0F);
        $display("test registers done");
        busPowerCtrlEn <= 1'b1;
        busPowerCtrlOut <= 1'b1;
        identPinEn <= 1'b1;
        extMemIfEn <= 1'b1;
        extMemAle <= 1'b1;
        extMemWr <= 1'b1;
        extIrqEn <= 4'hF;
        sleepInputOff <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check({24'h0, portEOe}, 32'h87);
        check({28'h0, portEOut[7], portEOut[2:0]}, 32'hD);
        check({24'h0, portEDinEn}, 32'hF8);
        check({portAOut, portAPullup, 10'h0, usbIdentIn, hwBootSelect, extIrqIn}, 32'h2F);
        $display("test overrides done");
        walk(10'b0011011111, 10);
        check({31'h0, portFOe[6]}, 32'h1);
        scan(8'h02, 4, dout);
        check({28'h0, dout[3:0]}, 32'h1);
        check({31'h0, portFOe[6]}, 32'h0);
        walk(10'h003, 4);
        scan(8'h00, 8, dout);
        check({24'h0, dout}, 32'hFD);
        $display("test scan done");
        give_verdict();
    end
endmodule
